// >>> logic/tdmfr_group.sv
/*
 One local stream group: rate strobe and the registered data of its
 streams. Assumes the bus clock domain and a frame start pulse.
*/
`default_nettype none
module tdmfr_group #(
    parameter int N = 4
) (
    input  wire logic         busClk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         frameStart,
    input  wire logic [1:0]   rate,
    input  wire logic [N-1:0] txData,
    input  wire logic [N-1:0] linPin,
    output logic      [N-1:0] loutPin,
    output logic      [N-1:0] rxData,
    output logic              strobe
);
    logic [1:0] divCnt_reg;
    logic [1:0] lastCnt;

    initial begin
        if (N != tdmfr_pkg::GROUP_STREAMS) $error("tdmfr_group: bad N");
    end

    // Reserved code never strobes: streams hold
    always_comb begin
        unique case (rate)
            tdmfr_pkg::RATE_8M: lastCnt = 2'h0;
            tdmfr_pkg::RATE_4M: lastCnt = 2'h1;
            tdmfr_pkg::RATE_2M: lastCnt = 2'h3;
            default:            lastCnt = 2'h3;
        endcase
    end
    assign strobe = ce && (rate != 2'h3) && (divCnt_reg == lastCnt);

    always_ff @(posedge busClk or posedge rst) begin
        if (rst) begin
            divCnt_reg <= 2'h0;
        end else if (ce) begin
            if (frameStart || divCnt_reg == lastCnt) divCnt_reg <= 2'h0;
            else divCnt_reg <= divCnt_reg + 2'h1;
        end
    end

    // One strobe serves every stream of the group alike
    always_ff @(posedge busClk or posedge rst) begin
        if (rst) begin
            loutPin <= '0;
            rxData  <= '0;
        end else if (strobe) begin
            loutPin <= txData;
            rxData  <= linPin;
        end
    end

    chk_group_same: assert property (@(posedge busClk) disable iff (rst)
        strobe |=> (loutPin == $past(txData)) && (rxData == $past(linPin)))
        else $error("group streams not updated together");
    chk_half_rate: assert property (@(posedge busClk) disable iff (rst)
        (strobe && rate == 2'h1 && !frameStart) |=>
        (!strobe || $changed(rate)))
        else $error("4.096 rate strobed twice in a row");
endmodule
`default_nettype wire

// >>> logic/tdmfr_pkg.sv
/*
 Constants, register map and carrier types for the TDM frame and rate
 configuration block. Assumes a 100 MHz system clock and an 8.192 MHz
 backplane bus clock.
*/
// What this block does
// - The frame reference copy in use is low for one bus clock, 122 ns, at each frame boundary and high for the rest of the frame.
// - The frame boundary is the bus clock rising edge seen while the frame reference is low.
// - With the backplane rate select at 0 all 32 backplane streams run at 8.192 Mbps.
// - With the backplane rate select at 1 only streams 0 to 15 run, at 16.384 Mbps.
// - Backplane rate and local group rates are applied independently of each other.
// - Sixteen local inputs and sixteen outputs form four groups of four of each.
// - Group n holds local streams 4n to 4n+3.
// - A group's two-bit rate field gives 00 8.192, 01 4.096, 10 2.048 Mbps, 11 reserved.
// - All streams of one group run identically at the group's rate.
// - While the active-low output gate input is high all 32 backplane stream pins float; here only after its synchroniser, up to four bus clocks later.
`default_nettype none
package tdmfr_pkg;
    localparam int          NUM_GROUPS    = 4;
    localparam int          GROUP_STREAMS = 4;
    localparam int          BP_STREAMS    = 32;
    localparam int          BP_HI_STREAMS = 16;
    localparam int          FRAME_US      = 125;
    localparam int          BUS_CLK_KHZ   = 8192;
    localparam int          FRAME_LOW_NS  = 122;
    localparam int          FRAME_CYC = FRAME_US * BUS_CLK_KHZ / 1000;
    localparam int          FRAME_LOW_RAW = FRAME_LOW_NS * BUS_CLK_KHZ
                                            / 1000000;
    localparam int          FRAME_LOW_CYC = (FRAME_LOW_RAW > 0) ?
                                            FRAME_LOW_RAW : 1;
    localparam logic [11:0] MODE_OFS      = 12'h000;
    localparam logic [11:0] STATUS_OFS    = 12'h004;
    localparam int          MODE_BP_POS   = 0;
    localparam int          MODE_GRP_POS  = 2;
    localparam int          MODE_SELB_POS = 10;
    localparam int          MODE_W        = 11;
    localparam logic [10:0] MODE_RESET    = 11'h000;
    localparam int          ST_LOCK_POS   = 0;
    localparam int          ST_WERR_POS   = 1;
    localparam int          ST_FCNT_POS   = 16;
    localparam logic [1:0]  RATE_8M       = 2'h0;
    localparam logic [1:0]  RATE_4M       = 2'h1;
    localparam logic [1:0]  RATE_2M       = 2'h2;

    typedef struct packed {
        logic             frameSelB;
        logic [3:0][1:0]  grpRate;
        logic [MODE_BP_POS+1-1:0] bpRate;
    } tdmfr_cfg_t;

    typedef struct packed {
        logic [15:0] frameCnt;
        logic        widthErr;
        logic        locked;
    } tdmfr_stat_t;
endpackage
`default_nettype wire

// >>> logic/tdmfr_sync3.sv
/*
 Three-stage level synchroniser; the output follows once stages two and
 three agree. Assumes bits are independent or gray coded.
*/
`default_nettype none
module tdmfr_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1Reg;
    logic [W-1:0] s2Reg;
    logic [W-1:0] s3Reg;

    initial begin
        if (W < 1) $error("tdmfr_sync3: W must be at least 1");
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1Reg <= '0;
            s2Reg <= '0;
            s3Reg <= '0;
        end else begin
            s1Reg <= d;
            s2Reg <= s1Reg;
            s3Reg <= s2Reg;
        end
    end

    // Per-bit agreement filters a stage-two glitch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2Reg[i] == s3Reg[i]) q[i] <= s3Reg[i];
            end
        end
    end
endmodule
`default_nettype wire

// >>> logic/tdmfr_top.sv
/*
 Frame alignment and rate configuration of the TDM switch: APB register
 slave on clk, backplane and local stream timing on the bus clock.
 Assumes bus clock and frame references come from the backplane.
*/
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none
module tdmfr_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        busClk,
    input  wire logic        frameRefAN,
    input  wire logic        frameRefBN,
    input  wire logic        bpOutGateN,
    input  wire logic [31:0] bpTxData,
    output logic      [31:0] bpRxData,
    input  wire logic [31:0] bpStreamIn,
    output logic      [31:0] bpStreamOut,
    output logic      [31:0] bpStreamOe,
    input  wire logic [15:0] localTxData,
    output logic      [15:0] localRxData,
    input  wire logic [15:0] localInStream,
    output logic      [15:0] localOutStream,
    output logic      [3:0]  groupStrobe,
    output logic             frameStart,
    output logic      [10:0] bpBitIdx
);
    localparam int NG = tdmfr_pkg::NUM_GROUPS;
    localparam int NS = tdmfr_pkg::GROUP_STREAMS;
    // Carrier is narrower than the mode word: fields mapped one by one
    localparam tdmfr_pkg::tdmfr_cfg_t CFG_RST = '{
        frameSelB: tdmfr_pkg::MODE_RESET[tdmfr_pkg::MODE_SELB_POS],
        grpRate:   tdmfr_pkg::MODE_RESET[tdmfr_pkg::MODE_GRP_POS +: 8],
        bpRate:    tdmfr_pkg::MODE_RESET[tdmfr_pkg::MODE_BP_POS]
    };

    initial begin
        if (NG * NS != 16) $error("tdmfr_top: local stream count");
        if (tdmfr_pkg::FRAME_CYC != 1024) $error("tdmfr_top: frame length");
    end

    // System clock domain: APB slave
    logic [10:0]           mode_reg;
    tdmfr_pkg::tdmfr_cfg_t shadow_reg;
    logic                  req_reg;
    logic                  ackC;
    logic [31:0]           rdata_next;
    logic                  apbWr;
    logic [17:0]           statC;
    logic [15:0]           fcntBin;
    tdmfr_pkg::tdmfr_cfg_t cfgC;

    assign pready  = 1'b1;
    assign apbWr   = ce && psel && penable && pwrite;
    assign pslverr = psel && penable &&
                     (paddr != tdmfr_pkg::MODE_OFS) &&
                     (paddr != tdmfr_pkg::STATUS_OFS);

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            // Gray to binary: each bit folds all bits above it
            fcntBin[i] = ^(statC[17:2] >> i);
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (paddr == tdmfr_pkg::MODE_OFS) begin
            rdata_next[tdmfr_pkg::MODE_W-1:0] = mode_reg;
        end else if (paddr == tdmfr_pkg::STATUS_OFS) begin
            rdata_next[tdmfr_pkg::ST_LOCK_POS]    = statC[0];
            rdata_next[tdmfr_pkg::ST_WERR_POS]    = statC[1];
            rdata_next[tdmfr_pkg::ST_FCNT_POS+:16] = fcntBin;
        end
    end

    // Read data caught in setup, so the access phase needs no wait
    always_ff @(posedge clk or posedge rst) begin
        if (rst) prdata <= 32'h0000_0000;
        else if (ce && psel && !penable && !pwrite) prdata <= rdata_next;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= tdmfr_pkg::MODE_RESET;
        end else if (apbWr && paddr == tdmfr_pkg::MODE_OFS) begin
            mode_reg <= pwdata[tdmfr_pkg::MODE_W-1:0];
        end
    end

    // Mode bit 1 is unused and dropped here
    always_comb begin
        cfgC.frameSelB = mode_reg[tdmfr_pkg::MODE_SELB_POS];
        cfgC.grpRate   = mode_reg[tdmfr_pkg::MODE_GRP_POS +: 8];
        cfgC.bpRate    = mode_reg[tdmfr_pkg::MODE_BP_POS];
    end

    // Handshake: shadow only moves when the link side has taken the last
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shadow_reg <= CFG_RST;
            req_reg    <= 1'b0;
        end else if (ce && ackC == req_reg && shadow_reg != cfgC) begin
            shadow_reg <= cfgC;
            req_reg    <= ~req_reg;
        end
    end

    // Link domain
    logic                  ceL;
    logic                  reqL;
    logic                  ackL_reg;
    tdmfr_pkg::tdmfr_cfg_t cfgL_reg;
    logic                  gateOk;
    logic                  gateHiN;
    logic                  frmN_reg;
    logic                  frmPrevN_reg;
    logic [1:0]            lowCnt_reg;
    logic                  widthErr_reg;
    logic                  locked_reg;
    logic [15:0]           fcnt_reg;
    logic [15:0]           fcntGray_reg;
    logic [10:0]           bitCnt_reg;
    logic [31:0]           bpOut_reg;
    logic [31:0]           laneOn;

    tdmfr_sync3 #(.W(1)) u_ceSync (
        .clk (busClk),
        .rst (rst),
        .d   (ce),
        .q   (ceL)
    );
    tdmfr_sync3 #(.W(1)) u_reqSync (
        .clk (busClk),
        .rst (rst),
        .d   (req_reg),
        .q   (reqL)
    );
    tdmfr_sync3 #(.W(1)) u_ackSync (
        .clk (clk),
        .rst (rst),
        .d   (ackL_reg),
        .q   (ackC)
    );
    // Gate is a free pin: synced, so float takes up to four bus clocks
    tdmfr_sync3 #(.W(1)) u_gateSync (
        .clk (busClk),
        .rst (rst),
        .d   (bpOutGateN),
        .q   (gateHiN)
    );
    tdmfr_sync3 #(.W(18)) u_statSync (
        .clk (clk),
        .rst (rst),
        .d   ({fcntGray_reg, widthErr_reg, locked_reg}),
        .q   (statC)
    );
    assign gateOk = !gateHiN;

    always_ff @(posedge busClk or posedge rst) begin
        if (rst) begin
            cfgL_reg <= CFG_RST;
            ackL_reg <= 1'b0;
        end else if (ceL && reqL != ackL_reg) begin
            cfgL_reg <= shadow_reg;
            ackL_reg <= reqL;
        end
    end

    // Reference is synchronous to the bus clock: sampled directly
    always_ff @(posedge busClk or posedge rst) begin
        if (rst) begin
            frmN_reg     <= 1'b1;
            frmPrevN_reg <= 1'b1;
        end else if (ceL) begin
            frmN_reg     <= cfgL_reg.frameSelB ? frameRefBN : frameRefAN;
            frmPrevN_reg <= frmN_reg;
        end
    end
    assign frameStart = ceL && !frmN_reg && frmPrevN_reg;

    always_ff @(posedge busClk or posedge rst) begin
        if (rst) begin
            lowCnt_reg   <= 2'h0;
            widthErr_reg <= 1'b0;
        end else if (ceL) begin
            if (frmN_reg) lowCnt_reg <= 2'h0;
            else if (lowCnt_reg != 2'h3) lowCnt_reg <= lowCnt_reg + 2'h1;
            if (!frmN_reg && lowCnt_reg >= 2'(tdmfr_pkg::FRAME_LOW_CYC))
                widthErr_reg <= 1'b1;
            else if (frameStart)
                widthErr_reg <= 1'b0;
        end
    end

    always_ff @(posedge busClk or posedge rst) begin
        if (rst) begin
            locked_reg   <= 1'b0;
            fcnt_reg     <= 16'h0000;
            fcntGray_reg <= 16'h0000;
        end else if (frameStart) begin
            locked_reg   <= 1'b1;
            fcnt_reg     <= fcnt_reg + 16'h0001;
            fcntGray_reg <= (fcnt_reg + 16'h0001) ^
                            ((fcnt_reg + 16'h0001) >> 1);
        end
    end

    // Bit periods since the boundary; two per bus clock at 16.384 Mbps
    always_ff @(posedge busClk or posedge rst) begin
        if (rst) begin
            bitCnt_reg <= 11'h000;
        end else if (ceL) begin
            if (frameStart) bitCnt_reg <= 11'h000;
            else if (cfgL_reg.bpRate[0])
                bitCnt_reg <= bitCnt_reg + 11'h002;
            else bitCnt_reg <= bitCnt_reg + 11'h001;
        end
    end
    assign bpBitIdx = bitCnt_reg;

    always_comb begin
        for (int s = 0; s < tdmfr_pkg::BP_STREAMS; s++) begin
            laneOn[s] = (s < tdmfr_pkg::BP_HI_STREAMS) ||
                        !cfgL_reg.bpRate[0];
        end
    end
    assign bpStreamOe = (gateOk && locked_reg) ?
                        laneOn : 32'h0000_0000;

    always_ff @(posedge busClk or posedge rst) begin
        if (rst) begin
            bpOut_reg <= 32'h0000_0000;
            bpRxData  <= 32'h0000_0000;
        end else if (ceL) begin
            bpOut_reg <= bpTxData & laneOn;
            bpRxData  <= bpStreamIn & laneOn;
        end
    end
    assign bpStreamOut = bpOut_reg;

    genvar g;
    generate
        for (g = 0; g < NG; g++) begin : gen_grp
            tdmfr_group #(.N(NS)) u_grp (
                .busClk     (busClk),
                .rst        (rst),
                .ce         (ceL),
                .frameStart (frameStart),
                .rate       (cfgL_reg.grpRate[g]),
                .txData     (localTxData[g*NS +: NS]),
                .linPin     (localInStream[g*NS +: NS]),
                .loutPin    (localOutStream[g*NS +: NS]),
                .rxData     (localRxData[g*NS +: NS]),
                .strobe     (groupStrobe[g])
            );
        end
    endgenerate

    chk_boundary_low: assert property (@(posedge busClk) disable iff (rst)
        (frameStart && $past(ceL)) |->
        !$past(cfgL_reg.frameSelB ? frameRefBN : frameRefAN))
        else $error("boundary taken with reference high");
    chk_bitcnt_zero: assert property (@(posedge busClk) disable iff (rst)
        frameStart |=> (bitCnt_reg == 11'h000))
        else $error("bit count not cleared at boundary");
    chk_wide_pulse: assert property (@(posedge busClk) disable iff (rst)
        (ceL && !frmN_reg)[*2] |=> widthErr_reg)
        else $error("wide frame pulse not flagged");
    chk_gate_float: assert property (@(posedge busClk) disable iff (rst)
        bpOutGateN[*4] |=> (bpStreamOe == 32'h0000_0000))
        else $error("backplane driven while gate high");
    chk_upper_off: assert property (@(posedge busClk) disable iff (rst)
        cfgL_reg.bpRate[0] |-> (bpStreamOe[31:16] == 16'h0000))
        else $error("upper streams driven at 16 Mbps");
    chk_all_lanes: assert property (@(posedge busClk) disable iff (rst)
        (!cfgL_reg.bpRate[0] && gateOk && locked_reg) |-> (&bpStreamOe))
        else $error("a stream idle at 8 Mbps");
    chk_double_step: assert property (@(posedge busClk) disable iff (rst)
        (ceL && !frameStart && cfgL_reg.bpRate[0]) |=>
        (bitCnt_reg == $past(bitCnt_reg) + 11'h002))
        else $error("16 Mbps bit count step wrong");
    chk_mode_write: assert property (@(posedge clk) disable iff (rst)
        (apbWr && paddr == tdmfr_pkg::MODE_OFS) |=>
        (mode_reg == $past(pwdata[10:0])))
        else $error("mode register write lost");
    chk_frame_lock: assert property (@(posedge busClk) disable iff (rst)
        frameStart |=> locked_reg)
        else $error("no lock after a boundary");
    chk_cfg_handoff: assert property (@(posedge busClk) disable iff (rst)
        (ceL && reqL != ackL_reg) |=> (cfgL_reg == $past(shadow_reg)))
        else $error("link config not taken from shadow");
    chk_lane_mask: assert property (@(posedge busClk) disable iff (rst)
        ceL |=> (bpRxData == ($past(bpStreamIn) & $past(laneOn))))
        else $error("backplane sample not masked by rate");
endmodule
`default_nettype wire

// >>> test/tb_top.sv
/*
 Self-checking bench for the frame and rate block: APB tasks, stream
 and strobe checks. Assumes the card model makes the bus clock.
*/
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          FLEN = 64;
    localparam logic [31:0] PAT  = 32'h5A3C96E1;
    localparam logic [31:0] BPTX = 32'hC3A50F96;
    localparam logic [15:0] LTX  = 16'h9A6C;
    localparam logic [15:0] LRX  = 16'h35E1;
    logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic        busClk, frameRefAN, frameRefBN, bpOutGateN;
    logic        frameStart, wideFrame, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, bpTxData, bpRxData, bpStreamIn, rd;
    logic [31:0] bpStreamOut, bpStreamOe;
    logic [15:0] localTxData, localRxData, localInStream, localOutStream;
    logic [3:0]  groupStrobe;
    logic [10:0] bpBitIdx;
    logic [15:0] fc;
    int          mismatches, n_compared, cycles, nFr;
    int          cnt [4];

    tdmfr_top i_dut (
        .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busClk(busClk),
        .frameRefAN(frameRefAN), .frameRefBN(frameRefBN),
        .bpOutGateN(bpOutGateN), .bpTxData(bpTxData), .bpRxData(bpRxData),
        .bpStreamIn(bpStreamIn), .bpStreamOut(bpStreamOut),
        .bpStreamOe(bpStreamOe), .localTxData(localTxData),
        .localRxData(localRxData), .localInStream(localInStream),
        .localOutStream(localOutStream), .groupStrobe(groupStrobe),
        .frameStart(frameStart), .bpBitIdx(bpBitIdx)
    );
    tdmfr_bp_card #(.FLEN(FLEN), .PAT(PAT)) i_card (
        .busClk(busClk), .frameRefAN(frameRefAN), .frameRefBN(frameRefBN),
        .bpStreamIn(bpStreamIn), .wideFrame(wideFrame)
    );

    always #5 clk = ~clk;
    // Ceiling well above the expected run of about 16000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            mismatches++;
            $display("wrong value at %0t: count %0d exp %0d", $time, got, exp);
        end
    endtask
    task automatic apb_xfer(input logic wr, input logic [11:0] a,
                            input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic bwait(input int n);
        repeat (n) @(posedge busClk);
        #1;
    endtask
    task automatic wait_frame(output int n);
        n = 0;
        do begin
            bwait(1);
            n++;
        end while (frameStart !== 1'b1 && n < 4 * FLEN);
        chk_val({31'h0, frameStart}, 32'h1);
        bwait(1);
    endtask
    task automatic count_strobes();
        cnt = '{0, 0, 0, 0};
        repeat (FLEN) begin
            bwait(1);
            for (int g = 0; g < 4; g++) cnt[g] += groupStrobe[g];
        end
    endtask
    // Codes 0 to 2 only; the reserved code is never written
    function automatic logic [1:0] rate_of(input int g, input int k);
        return 2'((g + (k > 2 ? 2 : k)) % 3);
    endfunction
    function automatic logic [31:0] mode_word(input int k);
        logic [31:0] w;
        w = '0;
        w[tdmfr_pkg::MODE_BP_POS] = k[0];
        for (int g = 0; g < 4; g++)
            w[tdmfr_pkg::MODE_GRP_POS + 2 * g +: 2] = rate_of(g, k);
        return w;
    endfunction

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        bpTxData = BPTX;
        localTxData = LTX;
        localInStream = LRX;
        bpOutGateN = 1'b0;
        wideFrame = 1'b0;
        // Bus clock cycles, so the synchronisers clear too
        repeat (4) @(posedge busClk);
        @(posedge clk);
        rst <= 1'b0;
        apb_xfer(1'b0, tdmfr_pkg::MODE_OFS, '0);
        chk_val(rd, 32'h0);
        apb_xfer(1'b0, tdmfr_pkg::STATUS_OFS, '0);
        chk_val(rd & 32'h3, 32'h0);
        chk_val(bpStreamOe, 32'h0);
        apb_xfer(1'b1, 12'h00C, 32'hFFFFFFFF);
        chk_val({31'h0, err}, 32'h1);
        apb_xfer(1'b0, tdmfr_pkg::MODE_OFS, '0);
        chk_val(rd, 32'h0);
        wait_frame(nFr);
        chk_val({21'h0, bpBitIdx}, 32'h0);
        wait_frame(nFr);
        chk_cnt(nFr, FLEN - 1);
        chk_cnt(i_card.cnt, 3);
        // Let the frame count cross into the register clock first
        bwait(1);
        apb_xfer(1'b0, tdmfr_pkg::STATUS_OFS, '0);
        chk_val(rd & 32'h1, 32'h1);
        fc = rd[31:16];
        wait_frame(nFr);
        bwait(1);
        apb_xfer(1'b0, tdmfr_pkg::STATUS_OFS, '0);
        chk_val({16'h0, rd[31:16] - fc}, 32'h1);
        bwait(8);
        chk_val(bpStreamOe, 32'hFFFFFFFF);
        chk_val(bpStreamOut, BPTX);
        chk_val({16'h0, localRxData}, {16'h0, LRX});
        for (int k = 0; k < 4; k++) begin
            apb_xfer(1'b1, tdmfr_pkg::MODE_OFS, mode_word(k));
            apb_xfer(1'b0, tdmfr_pkg::MODE_OFS, '0);
            chk_val(rd, mode_word(k));
            bwait(24);
            // Count from a boundary so the strobe phase is settled
            wait_frame(nFr);
            count_strobes();
            for (int g = 0; g < 4; g++)
                chk_cnt(cnt[g], FLEN >> rate_of(g, k));
            chk_val(bpStreamOe, k[0] ? 32'h0000FFFF : 32'hFFFFFFFF);
            chk_val(bpRxData, k[0] ? PAT & 32'h0000FFFF : PAT);
            chk_val({16'h0, localOutStream}, {16'h0, LTX});
        end
        @(posedge clk);
        bpOutGateN <= 1'b1;
        bwait(8);
        chk_val(bpStreamOe, 32'h0);
        @(posedge clk);
        bpOutGateN <= 1'b0;
        bwait(8);
        chk_val(bpStreamOe, 32'h0000FFFF);
        apb_xfer(1'b1, tdmfr_pkg::MODE_OFS,
                 mode_word(3) | (32'h1 << tdmfr_pkg::MODE_SELB_POS));
        bwait(24);
        wait_frame(nFr);
        wait_frame(nFr);
        chk_cnt(nFr, FLEN - 1);
        chk_cnt(i_card.cnt, FLEN / 2 + 3);
        @(posedge clk);
        wideFrame <= 1'b1;
        // The first boundary may predate the wide pulse
        wait_frame(nFr);
        wait_frame(nFr);
        @(posedge clk);
        wideFrame <= 1'b0;
        bwait(4);
        apb_xfer(1'b0, tdmfr_pkg::STATUS_OFS, '0);
        chk_val(rd & 32'h2, 32'h2);
        wrap_up();
    end
endmodule
`default_nettype wire

// >>> test/tdmfr_bp_card.sv
/*
 Backplane card model: bus clock, frame references and stream data.
 Assumes the block samples everything on the rising bus clock edge.
*/
`default_nettype none
module tdmfr_bp_card #(
    parameter int          FLEN = 64,
    parameter logic [31:0] PAT  = 32'h5A3C96E1
) (
    output logic        busClk,
    output logic        frameRefAN,
    output logic        frameRefBN,
    output logic [31:0] bpStreamIn,
    input  wire logic   wideFrame
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    initial begin
        busClk     = 1'b0;
        cnt        = 0;
        frameRefAN = 1'b1;
        frameRefBN = 1'b1;
        bpStreamIn = ~PAT;
        #23;
        forever #80 busClk = ~busClk;
    end
    // Short frame keeps the run brief; wideFrame breaks the width
    // B copy sits half a frame away, so the chosen copy is visible
    always @(posedge busClk) begin
        cnt        <= (cnt == FLEN - 1) ? 0 : cnt + 1;
        frameRefAN <= !(cnt == 0 || (wideFrame && cnt == 1));
        frameRefBN <= !(cnt == FLEN / 2 ||
                        (wideFrame && cnt == FLEN / 2 + 1));
        bpStreamIn <= PAT;
    end
endmodule
`default_nettype wire
